//--- design/gfs_fs_gen.sv
// frame-sync generator: high and low phases counted in timebase ticks
`timescale 1ns/100ps
module gfs_fs_gen
	import gfs_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	gfs_fs_if.gen     fs
);
	typedef enum logic [1:0] {S_IDLE, S_HIGH, S_LOW} gfs_gen_state_type;

	gfs_gen_state_type state_r;
	logic [15:0]       cnt_r;

	// phase sequencing; a one-shot is taken only while idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= S_IDLE;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (fs.cont_en || fs.shot) begin
						state_r <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (fs.tick && cnt_r == fs.high_per) begin
						state_r <= S_LOW;
					end
				end
				S_LOW: begin
					// whole low phase elapses before any new pulse
					if (fs.tick && cnt_r == fs.low_per) begin
						state_r <= fs.cont_en ? S_HIGH : S_IDLE;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// phase counter, programmed value plus one ticks per phase
	always_ff @(posedge clk_i) begin
		if (rst_i || state_r == S_IDLE) begin
			cnt_r <= 16'h0000;
		end else if (fs.tick) begin
			if ((state_r == S_HIGH && cnt_r == fs.high_per) ||
				(state_r == S_LOW && cnt_r == fs.low_per)) begin
				cnt_r <= 16'h0000;
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	assign fs.busy   = (state_r != S_IDLE);
	assign fs.strobe = (state_r == S_HIGH);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	high_one_tick_a: assert property ($rose(fs.strobe) && fs.tick &&
		fs.high_per == 16'h0000 |=> !fs.strobe)
		else $error("zero high period did not give a one-tick pulse");
	low_phase_hold_a: assert property (state_r == S_LOW &&
		!(fs.tick && cnt_r == fs.low_per) |=> state_r == S_LOW)
		else $error("new pulse began before low phase ended");
	shot_start_a: assert property (state_r == S_IDLE && fs.shot
		|=> fs.strobe ##0 fs.busy)
		else $error("one-shot request did not start a pulse");
	shot_cover_c: cover property (state_r == S_IDLE && fs.shot && !fs.cont_en);
	cont_cover_c: cover property (state_r == S_LOW && fs.cont_en ##1 fs.strobe);
endmodule

//--- design/gfs_fs_if.sv
// link between the register side and the frame-sync generator
`timescale 1ns/100ps
interface gfs_fs_if;
	logic        tick;
	logic        cont_en;
	logic        shot;
	logic [15:0] high_per;
	logic [15:0] low_per;
	logic        busy;
	logic        strobe;

	modport ctl (output tick, output cont_en, output shot, output high_per,
		output low_per, input busy, input strobe);
	modport gen (input tick, input cont_en, input shot, input high_per,
		input low_per, output busy, output strobe);
endinterface

//--- design/gfs_pin3_ctl.sv
// pin-3 output multiplexer and frame-sync control with a wishbone slave
//
// Functional notes
// - source field bits 4:2 picks port 0 (000), port 1 (001) or device status (100).
// - with a port as source, selection 000-011 gives remote pins 0-3, 100 lock, 101 pass.
// - with status as source, selection gives value bit, lock OR, lock AND, pass AND, strobe.
// - bit 0 enables the pin as output and bit 1 is the level of the value selection.
// - mode 0000 or 0001 times the generator from port 0 or port 1 back-channel clock.
// - mode 0100 times the generator from the 25 MHz reference; 0010, 0011, 0101-0111 reserved.
// - modes 1000-1011 take the strobe from general pins 0-3; 1100-1111 are reserved.
// - writing 1 to bit 3 of frame_sync_control emits exactly one strobe pulse while the generator is idle in mode 0000, 0001 or 0100.
// - after a one-shot the full high and low duration elapses before another pulse.
// - the one-shot bit clears itself and always reads back 0.
// - high and low periods hold the wanted tick count minus one, so 0 gives one tick.
`timescale 1ns/100ps
module gfs_pin3_ctl
	import gfs_pkg::*;
#(
	parameter int PORTS  = 2,
	parameter int PINS   = 4,
	parameter int ADDR_W = 12
)(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [ADDR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic [PORTS*PINS-1:0] rx_pins_i,
	input  wire logic [PORTS-1:0]     rx_lock_i,
	input  wire logic [PORTS-1:0]     rx_pass_i,
	input  wire logic [PORTS-1:0]     rx_enable_i,
	input  wire logic [PORTS-1:0]     bc_tick_i,
	input  wire logic                 ref_tick_i,
	input  wire logic [PINS-1:0]      gp_pin_i,
	output logic                      pin3_out_o,
	output logic                      pin3_oe_o,
	output logic                      frame_strobe_o,
	output logic                      fs_busy_o
);
	gfs_fs_if fs_bus ();

	logic [7:0]  pin3_ctl_r;
	logic [7:0]  frame_sync_control_r;
	logic [15:0] fs_high_r;
	logic [15:0] fs_low_r;
	logic        ack_r;
	logic [31:0] rd_nxt;
	logic [31:0] rd_r;
	logic        shot_r;
	logic        pin_nxt;
	logic        strobe_nxt;
	logic        tick_nxt;
	logic        gen_mode;
	logic        ext_mode;
	logic [7:0]  idx;
	logic        req;
	logic        wr_fire;
	logic        lock_or;
	logic        lock_and;
	logic        pass_and;
	logic [2:0]  src;
	logic [2:0]  sel;
	logic [3:0]  mode;

	// field views and bus decode
	assign src     = pin3_ctl_r[PIN3_SRC_MSB:PIN3_SRC_LSB];
	assign sel     = pin3_ctl_r[PIN3_SEL_MSB:PIN3_SEL_LSB];
	assign mode    = frame_sync_control_r[FRAME_SYNC_SOURCE_MODE_MSB:FRAME_SYNC_SOURCE_MODE_LSB];
	assign idx     = wb_adr_i[9:2];
	assign req     = wb_cyc_i && wb_stb_i;
	assign wr_fire = req && wb_we_i && ack_r && wb_sel_i[0];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req && !ack_r;
		end
	end

	// read data, unmapped and reserved indices read zero
	always_comb begin
		rd_nxt = WB_RD_ZERO;
		case (idx)
			IDX_PIN3_CTL: begin
				rd_nxt[7:0] = pin3_ctl_r;
			end
			IDX_FRAME_SYNC_CONTROL: begin
				rd_nxt[7:0] = frame_sync_control_r; // one-shot bit is never stored
			end
			IDX_FS_HIGH_MSB: begin
				rd_nxt[7:0] = fs_high_r[15:8];
			end
			IDX_FS_HIGH_LSB: begin
				rd_nxt[7:0] = fs_high_r[7:0];
			end
			IDX_FS_LOW_MSB: begin
				rd_nxt[7:0] = fs_low_r[15:8];
			end
			IDX_FS_LOW_LSB: begin
				rd_nxt[7:0] = fs_low_r[7:0];
			end
			default: begin
				rd_nxt = WB_RD_ZERO;
			end
		endcase
	end

	// read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_r <= WB_RD_ZERO;
		end else if (req && !ack_r && !wb_we_i) begin
			rd_r <= rd_nxt;
		end else if (!req) begin
			rd_r <= WB_RD_ZERO;
		end
	end

	// pin control register, written at the acked edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin3_ctl_r <= PIN3_CTL_RST;
		end else if (wr_fire && idx == IDX_PIN3_CTL) begin
			pin3_ctl_r <= wb_dat_i[7:0];
		end
	end

	// frame-sync control; the one-shot bit is dropped on store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_sync_control_r <= FRAME_SYNC_CONTROL_RST;
		end else if (wr_fire && idx == IDX_FRAME_SYNC_CONTROL) begin
			frame_sync_control_r <= wb_dat_i[7:0] & FRAME_SYNC_CONTROL_STORE_MASK;
		end
	end

	// one-cycle request to the generator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shot_r <= 1'b0;
		end else begin
			shot_r <= wr_fire && idx == IDX_FRAME_SYNC_CONTROL && wb_dat_i[FS_SHOT_BIT];
		end
	end

	// high and low periods, stored as count minus one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs_high_r <= FS_TIME_RST;
			fs_low_r  <= FS_TIME_RST;
		end else if (wr_fire) begin
			case (idx)
				IDX_FS_HIGH_MSB: begin
					fs_high_r[15:8] <= wb_dat_i[7:0];
				end
				IDX_FS_HIGH_LSB: begin
					fs_high_r[7:0] <= wb_dat_i[7:0];
				end
				IDX_FS_LOW_MSB: begin
					fs_low_r[15:8] <= wb_dat_i[7:0];
				end
				IDX_FS_LOW_LSB: begin
					fs_low_r[7:0] <= wb_dat_i[7:0];
				end
				default: begin
					fs_high_r <= fs_high_r;
				end
			endcase
		end
	end

	// timebase choice for the internal generator
	always_comb begin
		gen_mode = 1'b1;
		tick_nxt = 1'b0;
		case (mode)
			FRAME_SYNC_SOURCE_MODE_BC0: begin
				tick_nxt = bc_tick_i[0];
			end
			FRAME_SYNC_SOURCE_MODE_BC1: begin
				tick_nxt = bc_tick_i[1];
			end
			FRAME_SYNC_SOURCE_MODE_REF: begin
				tick_nxt = ref_tick_i;
			end
			default: begin
				gen_mode = 1'b0; // reserved and external-pin codes stop the generator
			end
		endcase
	end

	assign ext_mode = (mode[3:2] == FRAME_SYNC_SOURCE_MODE_EXT_TOP);

	// generator hookup; stopped while the mode is not internal
	assign fs_bus.tick     = tick_nxt;
	assign fs_bus.cont_en  = gen_mode && frame_sync_control_r[FS_CONT_BIT];
	assign fs_bus.shot     = gen_mode && shot_r;
	assign fs_bus.high_per = fs_high_r;
	assign fs_bus.low_per  = fs_low_r;

	gfs_fs_gen u_gen (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.fs    (fs_bus.gen)
	);

	// strobe source: generator, external pin or low
	always_comb begin
		if (gen_mode) begin
			strobe_nxt = fs_bus.strobe;
		end else if (ext_mode) begin
			strobe_nxt = gp_pin_i[mode[1:0]];
		end else begin
			strobe_nxt = 1'b0;
		end
	end

	// device status terms over enabled ports
	assign lock_or  = |(rx_lock_i & rx_enable_i);
	assign lock_and = (|rx_enable_i) && &(rx_lock_i | ~rx_enable_i);
	assign pass_and = (|rx_enable_i) && &(rx_pass_i | ~rx_enable_i);

	// pin data multiplexer
	always_comb begin
		pin_nxt = 1'b0; // reserved codes give low
		if (src == SRC_PORT0 || src == SRC_PORT1) begin
			if (!sel[2]) begin
				pin_nxt = rx_pins_i[src[0]*PINS + sel[1:0]];
			end else if (sel == SEL_PORT_LOCK) begin
				pin_nxt = rx_lock_i[src[0]];
			end else if (sel == SEL_PORT_PASS) begin
				pin_nxt = rx_pass_i[src[0]];
			end
		end else if (src == SRC_STATUS) begin
			case (sel)
				SEL_DEV_VALUE: begin
					pin_nxt = pin3_ctl_r[PIN3_VAL_BIT];
				end
				SEL_DEV_LOCK_OR: begin
					pin_nxt = lock_or;
				end
				SEL_DEV_LOCK_AND: begin
					pin_nxt = lock_and;
				end
				SEL_DEV_PASS_AND: begin
					pin_nxt = pass_and;
				end
				SEL_DEV_STROBE: begin
					pin_nxt = strobe_nxt;
				end
				default: begin
					pin_nxt = 1'b0;
				end
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin3_out_o     <= 1'b0;
			pin3_oe_o      <= 1'b0;
			frame_strobe_o <= 1'b0;
			fs_busy_o      <= 1'b0;
		end else begin
			pin3_out_o     <= pin_nxt;
			pin3_oe_o      <= pin3_ctl_r[PIN3_EN_BIT];
			frame_strobe_o <= strobe_nxt;
			fs_busy_o      <= fs_bus.busy;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rd_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	port0_pin_a: assert property (src == SRC_PORT0 && sel == 3'h2
		|=> pin3_out_o == $past(rx_pins_i[2]))
		else $error("port 0 remote pin 2 not on pin");
	port_lock_a: assert property (src == SRC_PORT1 && sel == SEL_PORT_LOCK
		|=> pin3_out_o == $past(rx_lock_i[1]))
		else $error("port 1 lock not on pin");
	lock_or_a: assert property (src == SRC_STATUS && sel == SEL_DEV_LOCK_OR
		|=> pin3_out_o == $past(|(rx_lock_i & rx_enable_i)))
		else $error("lock OR not on pin");
	dev_value_a: assert property (src == SRC_STATUS && sel == SEL_DEV_VALUE
		|=> pin3_out_o == $past(pin3_ctl_r[PIN3_VAL_BIT]))
		else $error("value bit not on pin");
	rsvd_low_a: assert property ((src[1] || src > SRC_STATUS)
		|=> !pin3_out_o)
		else $error("reserved source did not drive low");
	oe_follow_a: assert property ($rose(pin3_ctl_r[PIN3_EN_BIT])
		|=> pin3_oe_o)
		else $error("output enable did not follow control bit");
	shot_reads_zero_a: assert property (wb_ack_o && !wb_we_i &&
		idx == IDX_FRAME_SYNC_CONTROL |-> !wb_dat_o[FS_SHOT_BIT])
		else $error("one-shot bit read back as one");
	shot_pulse_a: assert property (wr_fire && idx == IDX_FRAME_SYNC_CONTROL &&
		wb_dat_i[FS_SHOT_BIT] && !fs_bus.busy ##1 gen_mode |=> fs_bus.strobe)
		else $error("one-shot write gave no pulse");
	ext_pin_a: assert property (mode == 4'h9
		|=> frame_strobe_o == $past(gp_pin_i[1]))
		else $error("external strobe not taken from pin 1");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// further mux, enable and strobe-source checks
	port_pass_a: assert property (src == SRC_PORT0 && sel == SEL_PORT_PASS
		|=> pin3_out_o == $past(rx_pass_i[0]))
		else $error("port 0 pass not on pin");
	lock_and_a: assert property (src == SRC_STATUS && sel == SEL_DEV_LOCK_AND
		|=> pin3_out_o == $past((|rx_enable_i) &&
		((rx_lock_i & rx_enable_i) == rx_enable_i)))
		else $error("lock AND not on pin");
	pass_and_a: assert property (src == SRC_STATUS && sel == SEL_DEV_PASS_AND
		|=> pin3_out_o == $past((|rx_enable_i) &&
		((rx_pass_i & rx_enable_i) == rx_enable_i)))
		else $error("pass AND not on pin");
	rsvd_sel_a: assert property (!src[2] && !src[1] && sel[2:1] == 2'b11
		|=> !pin3_out_o)
		else $error("reserved selection did not drive low");
	pin_strobe_a: assert property (src == SRC_STATUS && sel == SEL_DEV_STROBE
		|=> pin3_out_o == frame_strobe_o)
		else $error("strobe not on pin");
	rsvd_mode_a: assert property (!gen_mode && !ext_mode |=> !frame_strobe_o)
		else $error("reserved mode let a strobe through");
	oe_fall_a: assert property ($fell(pin3_ctl_r[PIN3_EN_BIT]) |=> !pin3_oe_o)
		else $error("output enable did not drop with control bit");

	ext_cover_c: cover property (ext_mode && gp_pin_i[mode[1:0]]);
	status_strobe_c: cover property (src == SRC_STATUS && sel == SEL_DEV_STROBE
		&& pin3_out_o);
	ref_cover_c: cover property (mode == FRAME_SYNC_SOURCE_MODE_REF && fs_bus.strobe);
endmodule

//--- design/gfs_pkg.sv
// constants for the pin-3 output mux and frame-sync control block
package gfs_pkg;
	// word indices of the registers; byte address is four times the index
	localparam logic [7:0] IDX_PIN3_CTL    = 8'h13;
	localparam logic [7:0] IDX_RSVD_FIRST  = 8'h14;
	localparam logic [7:0] IDX_RSVD_LAST   = 8'h17;
	localparam logic [7:0] IDX_FRAME_SYNC_CONTROL      = 8'h18;
	localparam logic [7:0] IDX_FS_HIGH_MSB = 8'h19;
	localparam logic [7:0] IDX_FS_HIGH_LSB = 8'h1A;
	localparam logic [7:0] IDX_FS_LOW_MSB  = 8'h1B;
	localparam logic [7:0] IDX_FS_LOW_LSB  = 8'h1C;

	// reset values
	localparam logic [7:0]  PIN3_CTL_RST = 8'h00;
	localparam logic [7:0]  FRAME_SYNC_CONTROL_RST   = 8'h00;
	localparam logic [15:0] FS_TIME_RST  = 16'h0000;

	// pin3_output_control fields
	localparam int PIN3_SEL_MSB = 7;
	localparam int PIN3_SEL_LSB = 5;
	localparam int PIN3_SRC_MSB = 4;
	localparam int PIN3_SRC_LSB = 2;
	localparam int PIN3_VAL_BIT = 1;
	localparam int PIN3_EN_BIT  = 0;

	// frame_sync_control fields
	localparam int FRAME_SYNC_SOURCE_MODE_MSB  = 7;
	localparam int FRAME_SYNC_SOURCE_MODE_LSB  = 4;
	localparam int FS_SHOT_BIT  = 3;
	localparam int FS_CONT_BIT  = 0;
	localparam logic [7:0] FRAME_SYNC_CONTROL_STORE_MASK = 8'hF7;

	// source codes
	localparam logic [2:0] SRC_PORT0  = 3'h0;
	localparam logic [2:0] SRC_PORT1  = 3'h1;
	localparam logic [2:0] SRC_STATUS = 3'h4;

	// selection codes when a receive port is the source
	localparam logic [2:0] SEL_PORT_LOCK = 3'h4;
	localparam logic [2:0] SEL_PORT_PASS = 3'h5;

	// selection codes when device status is the source
	localparam logic [2:0] SEL_DEV_VALUE    = 3'h0;
	localparam logic [2:0] SEL_DEV_LOCK_OR  = 3'h1;
	localparam logic [2:0] SEL_DEV_LOCK_AND = 3'h2;
	localparam logic [2:0] SEL_DEV_PASS_AND = 3'h3;
	localparam logic [2:0] SEL_DEV_STROBE   = 3'h4;

	// frame_sync_source_mode codes
	localparam logic [3:0] FRAME_SYNC_SOURCE_MODE_BC0     = 4'h0;
	localparam logic [3:0] FRAME_SYNC_SOURCE_MODE_BC1     = 4'h1;
	localparam logic [3:0] FRAME_SYNC_SOURCE_MODE_REF     = 4'h4;
	localparam logic [1:0] FRAME_SYNC_SOURCE_MODE_EXT_TOP = 2'h2;

	// bus answer for unmapped reads
	localparam logic [31:0] WB_RD_ZERO = 32'h0000_0000;
endpackage

//--- tb/gpio_out_mux_frame_strobe_ctl_bench.sv
// self-checking bench for the pin-3 mux and frame-sync control
`timescale 1ns/100ps
module gpio_out_mux_frame_strobe_ctl_bench;
	import gfs_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic [7:0]  pins = 8'h00;
	logic [1:0]  lock = 2'h0;
	logic [1:0]  pass = 2'h0;
	logic [1:0]  en = 2'h0;
	logic [1:0]  bct = 2'h0;
	logic        reft = 1'b0;
	logic [3:0]  gp = 4'h0;
	logic        pout;
	logic        poe;
	logic        fstr;
	logic        fbusy;
	logic        prev_s = 1'b0;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cyc_n = 0;
	int          hi_n = 0;
	int          rise_n = 0;
	logic [31:0] q;
	int          h0;
	int          r0;
	int          len;
	logic [7:0]  vp [3] = '{8'hA5, 8'h5A, 8'h3C};
	logic [1:0]  vl [3] = '{2'h1, 2'h3, 2'h2};
	logic [1:0]  vs [3] = '{2'h2, 2'h3, 2'h1};
	logic [1:0]  ve [3] = '{2'h3, 2'h1, 2'h1};
	logic [3:0]  fm [3] = '{FRAME_SYNC_SOURCE_MODE_BC0, FRAME_SYNC_SOURCE_MODE_BC1, FRAME_SYNC_SOURCE_MODE_REF};

	gfs_pin3_ctl gfs_pin3_ctl_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rx_pins_i(pins), .rx_lock_i(lock),
		.rx_pass_i(pass), .rx_enable_i(en), .bc_tick_i(bct), .ref_tick_i(reft),
		.gp_pin_i(gp), .pin3_out_o(pout), .pin3_oe_o(poe),
		.frame_strobe_o(fstr), .fs_busy_o(fbusy));

	// clock
	always #50 clk_i = ~clk_i;

	// strobe high cycles and rising edges, plus the hang limit
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (fstr === 1'b1)
			hi_n <= hi_n + 1;
		if (fstr === 1'b1 && prev_s !== 1'b1)
			rise_n <= rise_n + 1;
		prev_s <= fstr;
		if (cyc_n == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask

	// one classic wishbone cycle, entered and left just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		cyc <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {2'h0, idx, 2'h0};
		wdat <= {24'h00_0000, d};
		@(posedge clk_i);
		// no local limit: only the bench cycle ceiling ends a hung wait
		while (ack !== 1'b1) begin
			@(posedge clk_i);
		end
		q = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		chk_word("read data", {24'h00_0000, e}, q);
	endtask

	// wait for the strobe to reach a level, then count how long it stays there
	task automatic run_len(input logic lvl, output int l);
		l = 0;
		while (fstr !== lvl && l < 60) begin
			@(posedge clk_i);
			l++;
		end
		l = 0;
		while (fstr === lvl && l < 60) begin
			@(posedge clk_i);
			l++;
		end
	endtask

	// pin value worked out from source, selection and the port inputs
	function automatic logic mux_exp(input logic [2:0] s, input logic [2:0] k, input logic v);
		logic [3:0] p;
		p = s[0] ? pins[7:4] : pins[3:0];
		if (s == SRC_PORT0 || s == SRC_PORT1) begin
			if (!k[2])
				return p[k[1:0]];
			if (k == SEL_PORT_LOCK)
				return lock[s[0]];
			return (k == SEL_PORT_PASS) ? pass[s[0]] : 1'b0;
		end
		if (s != SRC_STATUS)
			return 1'b0;
		case (k)
			SEL_DEV_VALUE:    return v;
			SEL_DEV_LOCK_OR:  return |(lock & en);
			SEL_DEV_LOCK_AND: return (en != 2'h0) && ((lock & en) == en);
			SEL_DEV_PASS_AND: return (en != 2'h0) && ((pass & en) == en);
			default:          return 1'b0;
		endcase
	endfunction

	// main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_bit("oe after reset", 1'b0, poe);
		for (int i = 8'h13; i <= 8'h1C; i++)
			rd_chk(i[7:0], 8'h00);
		wr(8'h14, 8'hFF);
		rd_chk(8'h14, 8'h00);
		rd_chk(8'h30, 8'h00);
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 8; k++) begin
				wr(IDX_PIN3_CTL, {k[2:0], s[2:0], k[0] ^ s[1], k[1] ^ s[0]});
				for (int j = 0; j < 3; j++) begin
					pins <= vp[j];
					lock <= vl[j];
					pass <= vs[j];
					en <= ve[j];
					repeat (3) @(posedge clk_i);
					chk_bit("pin out", mux_exp(s[2:0], k[2:0], k[0] ^ s[1]), pout);
					chk_bit("pin oe", k[1] ^ s[0], poe);
				end
			end
		end
		wr(IDX_FS_LOW_LSB, 8'h01);
		for (int i = 0; i < 3; i++) begin
			bct <= (i == 0) ? 2'h1 : ((i == 1) ? 2'h2 : 2'h0);
			reft <= (i == 2);
			wr(IDX_FS_HIGH_LSB, i[7:0]);
			wr(IDX_FRAME_SYNC_CONTROL, {fm[i], 4'h0});
			h0 = hi_n;
			r0 = rise_n;
			wr(IDX_FRAME_SYNC_CONTROL, {fm[i], 4'h8});
			wr(IDX_FRAME_SYNC_CONTROL, {fm[i], 4'h8});
			repeat (40) @(posedge clk_i);
			chk_word("strobe high cycles", i + 1, hi_n - h0);
			chk_word("strobe pulses", 1, rise_n - r0);
			chk_bit("busy at rest", 1'b0, fbusy);
			rd_chk(IDX_FRAME_SYNC_CONTROL, {fm[i], 4'h0});
		end
		rd_chk(IDX_FS_HIGH_LSB, 8'h02);
		wr(IDX_FRAME_SYNC_CONTROL, {FRAME_SYNC_SOURCE_MODE_REF, 4'h1});
		run_len(1'b0, len);
		run_len(1'b1, len);
		chk_word("high run", 3, len);
		run_len(1'b0, len);
		chk_word("low run", 2, len);
		chk_bit("busy running", 1'b1, fbusy);
		wr(IDX_FRAME_SYNC_CONTROL, {FRAME_SYNC_SOURCE_MODE_REF, 4'h0});
		bct <= 2'h3;
		foreach (fm[i]) begin
			wr(IDX_FRAME_SYNC_CONTROL, (i == 0) ? 8'h28 : ((i == 1) ? 8'h78 : 8'hC8));
			r0 = rise_n;
			repeat (30) @(posedge clk_i);
			chk_word("reserved mode pulses", 0, rise_n - r0);
		end
		wr(IDX_PIN3_CTL, 8'h91);
		rd_chk(IDX_PIN3_CTL, 8'h91);
		for (int k = 0; k < 4; k++) begin
			wr(IDX_FRAME_SYNC_CONTROL, {2'h2, k[1:0], 4'h0});
			gp <= 4'h1 << k;
			repeat (4) @(posedge clk_i);
			chk_bit("external strobe", 1'b1, fstr);
			chk_bit("pin strobe", 1'b1, pout);
			gp <= ~(4'h1 << k);
			repeat (4) @(posedge clk_i);
			chk_bit("external strobe", 1'b0, fstr);
			chk_bit("pin strobe", 1'b0, pout);
		end
		complete_run();
	end
endmodule
